// ==== logic/exe_pkg.sv ====
// Purpose: constants for the exception and interrupt entry unit
// Assumes: 32-bit addresses, status word layout fixed below
// Notes:   event codes are 12-bit values
package exe_pkg;
  localparam int unsigned SR_BL_BIT   = 28;
  localparam int unsigned SR_MD_BIT   = 30;
  localparam int unsigned SR_RB_BIT   = 29;
  localparam int unsigned SR_IM_LSB   = 4;
  localparam logic [31:0] SR_RESET    = 32'h700000f0;
  localparam logic [31:0] VEC_GEN     = 32'h00000100;
  localparam logic [31:0] VEC_INT     = 32'h00000600;
  localparam logic [31:0] RESET_ADDR  = 32'ha0000000;
  localparam logic [31:0] USER_LIMIT  = 32'h80000000;
  localparam logic [11:0] EV_PROT_RD  = 12'h0a0;
  localparam logic [11:0] EV_PROT_WR  = 12'h0c0;
  localparam logic [11:0] EV_ADE_RD   = 12'h0e0;
  localparam logic [11:0] EV_ADE_WR   = 12'h100;
  localparam logic [11:0] EV_TRAP     = 12'h160;
  localparam logic [11:0] EV_ILL_GEN  = 12'h180;
  localparam logic [11:0] EV_ILL_SLOT = 12'h1a0;
  localparam logic [11:0] EV_BREAK    = 12'h1e0;
  localparam logic [11:0] EV_DMA_ADE  = 12'h5c0;
  localparam logic [11:0] EV_NMI      = 12'h1c0;
  localparam logic [11:0] EV_LVL_BASE = 12'h200;
  localparam int unsigned EV_LVL_SHIFT = 5;
  localparam logic [31:0] ZERO32      = 32'h00000000;
  localparam logic [11:0] ZERO12      = 12'h000;
  localparam logic [21:0] ZERO22      = 22'h000000;
  localparam logic [9:0]  ZERO10      = 10'h000;
  localparam logic [1:0]  ZERO2       = 2'h0;
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_LONG     = 2'h2;
endpackage : exe_pkg

// ==== logic/exe_entry.sv ====
// Purpose: detects exceptions and interrupts and performs entry
// Assumes: pipeline presents one instruction boundary per cycle
// Notes:   at most one entry per cycle; losers are re-evaluated later
`timescale 1ns/10ps
// Operation
// - page rights checked per mode on hits
// - protection fault captures address, page, way
// - protection codes 0a0 read, 0c0 write
// - re-executing faults save own pc, status
// - general entry sets flags, vectors base+100
// - misaligned fetch, word, longword raise error
// - user access at upper half faults
// - address error captures address, 0e0 or 100
// - trap saves next pc, imm times four, 160
// - undefined or user privileged outside slot
// - illegal general saves own pc, 180
// - slot undefined, pc-changing, or user privileged faults
// - slot fault saves branch pc, 1a0
// - break code 1e0, pc by break kind
// - dma misalign saves next pc, 5c0
// - interrupt saves next pc, vectors base+600
// - nmi edge writes 1c0 to both codes
// - nmi ignores mask, held while blocked
// - level interrupt when mask below level
// - level code 200 plus level times 20
// - pin interrupt by priority, own code
// - blocked interrupts wait, sleep accepts level and pin anyway
// - blocked general fault jumps to reset address
module exe_entry (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        boundary,
  input  wire logic [31:0] cur_pc,
  input  wire logic [31:0] next_pc,
  input  wire logic [31:0] branch_pc,
  input  wire logic        in_slot,
  input  wire logic        op_valid,
  input  wire logic [15:0] opcode,
  input  wire logic        op_privileged,
  input  wire logic        op_global_base_only,
  input  wire logic        op_writes_pc,
  input  wire logic        op_undefined,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic        mem_fetch,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_vaddr,
  input  wire logic        tlb_hit,
  input  wire logic [1:0]  page_access_rights,
  input  wire logic [1:0]  tlb_way,
  input  wire logic        brk_req,
  input  wire logic        brk_post,
  input  wire logic        dma_valid,
  input  wire logic [1:0]  dma_size,
  input  wire logic [31:0] dma_addr,
  input  wire logic        nmi_pin,
  input  wire logic [3:0]  encoded_level_inputs,
  input  wire logic        pin_irq,
  input  wire logic [3:0]  pin_irq_priority,
  input  wire logic [11:0] pin_irq_code,
  input  wire logic        sleep_mode,
  input  wire logic        sr_load,
  input  wire logic [31:0] sr_load_value,
  input  wire logic        vbr_load,
  input  wire logic [31:0] vbr_load_value,
  output logic [31:0]      processor_status_word,
  output logic [31:0]      vector_base_reg,
  output logic [31:0]      saved_program_counter,
  output logic [31:0]      saved_status_copy,
  output logic [31:0]      fault_virtual_address_reg,
  output logic [21:0]      page_entry_high_reg,
  output logic [1:0]       mmu_way_counter,
  output logic [11:0]      exception_event_code,
  output logic [11:0]      interrupt_event_code,
  output logic [11:0]      interrupt_event_code_alt,
  output logic [9:0]       immediate_call_code,
  output logic             branch_valid,
  output logic [31:0]      branch_target
);
  logic [31:0] sr_ff, vbr_ff, spc_ff, ssr_ff, tea_ff, tgt_ff;
  logic [21:0] page_entry_high_reg_ff;
  logic [1:0]  rc_ff;
  logic [11:0] exception_event_code_ff, interrupt_event_code_ff, interrupt_event_code_alt_ff;
  logic [9:0]  tra_ff;
  logic        br_ff;
  logic        nmi_s1_ff, nmi_s2_ff, nmi_s3_ff, nmi_pend_ff;
  logic [3:0]  lvl_s1_ff, lvl_s2_ff;
  logic        pin_s1_ff, pin_s2_ff;

  wire         bl   = sr_ff[exe_pkg::SR_BL_BIT];
  wire         md   = sr_ff[exe_pkg::SR_MD_BIT];
  wire [3:0]   imsk = sr_ff[exe_pkg::SR_IM_LSB +: 4];

  wire rd_ok = md ? 1'b1 : page_access_rights[1];
  wire wr_ok = page_access_rights[0] & (md | page_access_rights[1]);
  wire prot  = mem_valid & !mem_fetch & tlb_hit &
               (mem_write ? !wr_ok : !rd_ok);
  wire mis_cpu = mem_fetch ? mem_vaddr[0] :
                 (mem_size == exe_pkg::SZ_WORD) ? mem_vaddr[0] :
                 (mem_size == exe_pkg::SZ_LONG) ? |mem_vaddr[1:0] : 1'b0;
  wire user_hi = !md & (mem_vaddr >= exe_pkg::USER_LIMIT);
  wire ade     = mem_valid & (mis_cpu | user_hi);
  wire dma_mis = dma_valid &
                 (((dma_size == exe_pkg::SZ_WORD) & dma_addr[0]) |
                  ((dma_size == exe_pkg::SZ_LONG) & |dma_addr[1:0]));
  wire undef_op = op_undefined | (opcode[15:12] == 4'hf);
  wire priv_bad = op_privileged & !op_global_base_only & !md;
  wire ill_gen  = op_valid & !in_slot & (undef_op | priv_bad);
  wire ill_slot = op_valid & in_slot & (undef_op | op_writes_pc | priv_bad);
  wire is_trap  = op_valid & !in_slot & (opcode[15:8] == 8'hc3);
  wire brk      = brk_req & !bl;

  wire nmi_edge = nmi_s2_ff & !nmi_s3_ff;
  wire int_ok   = boundary & (!bl | sleep_mode);
  wire take_nmi = nmi_pend_ff & boundary & !bl;
  wire take_lvl = int_ok & (imsk < lvl_s2_ff);
  wire take_pin = int_ok & pin_s2_ff & (imsk < pin_irq_priority);

  wire g_any = ade | prot | ill_slot | ill_gen | is_trap | brk | dma_mis;
  wire t_gen = g_any;
  wire t_nmi = !g_any & take_nmi;
  wire t_lvl = !g_any & !take_nmi & take_lvl;
  wire t_pin = !g_any & !take_nmi & !take_lvl & take_pin;
  wire t_int = t_nmi | t_lvl | t_pin;
  wire g_blk = t_gen & bl;

  wire [11:0] gcode =
    ade      ? (mem_write ? exe_pkg::EV_ADE_WR : exe_pkg::EV_ADE_RD) :
    prot     ? (mem_write ? exe_pkg::EV_PROT_WR : exe_pkg::EV_PROT_RD) :
    ill_slot ? exe_pkg::EV_ILL_SLOT :
    ill_gen  ? exe_pkg::EV_ILL_GEN :
    is_trap  ? exe_pkg::EV_TRAP :
    brk      ? exe_pkg::EV_BREAK : exe_pkg::EV_DMA_ADE;
  wire [31:0] gpc =
    (ade | prot | ill_gen) ? cur_pc :
    ill_slot ? branch_pc :
    is_trap  ? next_pc :
    brk      ? (brk_post ? next_pc : cur_pc) : next_pc;
  wire [11:0] lcode = exe_pkg::EV_LVL_BASE +
                      12'({lvl_s2_ff, 5'h00});
  wire [11:0] icode = t_nmi ? exe_pkg::EV_NMI :
                      t_lvl ? lcode : pin_irq_code;
  wire [31:0] sr_ent = sr_ff | (32'h1 << exe_pkg::SR_BL_BIT) |
                       (32'h1 << exe_pkg::SR_MD_BIT) |
                       (32'h1 << exe_pkg::SR_RB_BIT);
  wire [31:0] nxt_sr = (t_gen | t_int) ? sr_ent :
                       sr_load ? sr_load_value : sr_ff;
  wire [31:0] nxt_tgt = g_blk ? exe_pkg::RESET_ADDR :
                        t_gen ? vbr_ff + exe_pkg::VEC_GEN :
                        vbr_ff + exe_pkg::VEC_INT;
  wire take_any = t_gen | t_int;
  wire save_ctx = (t_gen & !bl) | t_int;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nmi_s1_ff <= 1'b0;
      nmi_s2_ff <= 1'b0;
      nmi_s3_ff <= 1'b0;
      lvl_s1_ff <= 4'h0;
      lvl_s2_ff <= 4'h0;
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_s1_ff <= nmi_pin;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
      lvl_s1_ff <= encoded_level_inputs;
      lvl_s2_ff <= lvl_s1_ff;
      pin_s1_ff <= pin_irq;
      pin_s2_ff <= pin_s1_ff;
      // held pending; new edge wins over acceptance
      nmi_pend_ff <= nmi_edge | (nmi_pend_ff & !t_nmi);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sr_ff  <= exe_pkg::SR_RESET;
      vbr_ff <= exe_pkg::ZERO32;
      br_ff  <= 1'b0;
      tgt_ff <= exe_pkg::RESET_ADDR;
    end else begin
      sr_ff  <= nxt_sr;
      vbr_ff <= vbr_load ? vbr_load_value : vbr_ff;
      br_ff  <= take_any;
      tgt_ff <= take_any ? nxt_tgt : tgt_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spc_ff <= exe_pkg::ZERO32;
      ssr_ff <= exe_pkg::ZERO32;
    end else if (save_ctx) begin
      spc_ff <= t_gen ? gpc : next_pc;
      ssr_ff <= sr_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tea_ff  <= exe_pkg::ZERO32;
      page_entry_high_reg_ff <= exe_pkg::ZERO22;
      rc_ff   <= exe_pkg::ZERO2;
    end else if (t_gen & !bl & (ade | prot)) begin
      tea_ff <= mem_vaddr;
      if (!ade) begin
        page_entry_high_reg_ff <= mem_vaddr[31:10];
        rc_ff   <= tlb_way;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exception_event_code_ff  <= exe_pkg::ZERO12;
      interrupt_event_code_ff  <= exe_pkg::ZERO12;
      interrupt_event_code_alt_ff <= exe_pkg::ZERO12;
      tra_ff     <= exe_pkg::ZERO10;
    end else begin
      if (t_gen & !bl)
        exception_event_code_ff <= gcode;
      if (t_gen & !bl & !ade & !prot & !ill_slot & !ill_gen & is_trap)
        tra_ff <= {opcode[7:0], 2'h0};
      if (t_int) begin
        interrupt_event_code_ff  <= icode;
        interrupt_event_code_alt_ff <= icode;
      end
    end
  end

  assign processor_status_word     = sr_ff;
  assign vector_base_reg           = vbr_ff;
  assign saved_program_counter     = spc_ff;
  assign saved_status_copy         = ssr_ff;
  assign fault_virtual_address_reg = tea_ff;
  assign page_entry_high_reg       = page_entry_high_reg_ff;
  assign mmu_way_counter           = rc_ff;
  assign exception_event_code      = exception_event_code_ff;
  assign interrupt_event_code      = interrupt_event_code_ff;
  assign interrupt_event_code_alt  = interrupt_event_code_alt_ff;
  assign immediate_call_code       = tra_ff;
  assign branch_valid              = br_ff;
  assign branch_target             = tgt_ff;

  gen_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (t_gen & !bl) |=> branch_valid &&
      branch_target == $past(vector_base_reg) + 32'h100)
    else $error("general entry vector wrong");
  blk_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    g_blk |=> branch_valid && branch_target == 32'ha0000000)
    else $error("blocked fault not at reset address");
  int_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    t_int |=> branch_target == $past(vbr_ff) + 32'h600)
    else $error("interrupt vector wrong");
  nmi_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bl & nmi_pend_ff & !g_any) |=>
      !branch_valid || interrupt_event_code != exe_pkg::EV_NMI)
    else $error("nmi taken while blocked");
  lvl_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    t_lvl |=> interrupt_event_code == 12'h200 + $past(lvl_s2_ff) * 12'h20)
    else $error("level code wrong");
  int_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    t_nmi |=> interrupt_event_code == 12'h1c0 &&
      interrupt_event_code_alt == 12'h1c0)
    else $error("nmi code wrong");
  ent_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_any |=> sr_ff[30:28] == 3'h7 &&
      sr_ff[7:4] == $past(sr_ff[7:4]))
    else $error("entry flags wrong");
  one_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    t_gen |=> $stable(interrupt_event_code) &&
      $stable(interrupt_event_code_alt))
    else $error("interrupt taken beside exception");
  trap_val_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (t_gen & !bl & gcode == 12'h160) |=>
      immediate_call_code == {$past(opcode[7:0]), 2'h0})
    else $error("trap value wrong");
endmodule : exe_entry

// ==== verification/exe_irq_src.sv ====
// Purpose: interrupt controller model driving the encoded level lines
// Assumes: request held until the unit reports its level code
// Notes:   drops the level once entry for that level is seen
`timescale 1ns/10ps
module exe_irq_src (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        raise,
  input  wire logic [3:0]  level,
  input  wire logic        branch_valid,
  input  wire logic [11:0] interrupt_event_code,
  output logic      [3:0]  encoded_level_inputs
);
  logic [11:0] ack_code;
  assign ack_code = 12'h200 + {3'h0, encoded_level_inputs, 5'h00};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) encoded_level_inputs <= 4'h0;
    else if (raise) encoded_level_inputs <= level;
    else if (branch_valid && interrupt_event_code == ack_code)
      encoded_level_inputs <= 4'h0;
  end
endmodule : exe_irq_src

// ==== verification/exe_entry_bench.sv ====
// Purpose: self-checking bench for the exception entry unit
// Assumes: outputs settle one cycle after the causing inputs
// Notes:   scenarios run in order; each leaves the block bit set
`timescale 1ns/10ps
module exe_entry_bench;
  logic clk_sys = 0, rst_n = 0, boundary = 1, in_slot = 0, op_valid = 0;
  logic op_privileged = 0, op_global_base_only = 0, op_writes_pc = 0;
  logic op_undefined = 0, mem_valid = 0, mem_write = 0, mem_fetch = 0;
  logic tlb_hit = 0, brk_req = 0, brk_post = 0, dma_valid = 0, raise = 0;
  logic nmi_pin = 0, pin_irq = 0, sleep_mode = 0, sr_load = 0, vbr_load = 0;
  logic [31:0] cur_pc = 32'h00001000, next_pc = 32'h00001002;
  logic [31:0] branch_pc = 32'h00000ffe, mem_vaddr = 0, dma_addr = 0;
  logic [31:0] sr_load_value = 0, vbr_load_value = 32'h8c000000;
  logic [15:0] opcode = 0;
  logic [1:0]  mem_size = 0, page_access_rights = 0, tlb_way = 0, dma_size = 0;
  logic [3:0]  pin_irq_priority = 0, level = 0, encoded_level_inputs;
  logic [11:0] pin_irq_code = 12'h600;
  logic [31:0] processor_status_word, vector_base_reg, saved_program_counter;
  logic [31:0] saved_status_copy, fault_virtual_address_reg, branch_target;
  logic [21:0] page_entry_high_reg;
  logic [1:0]  mmu_way_counter;
  logic [11:0] exception_event_code, interrupt_event_code;
  logic [11:0] interrupt_event_code_alt;
  logic [9:0]  immediate_call_code;
  logic        branch_valid;
  int          n_mismatch = 0, compares = 0;
  exe_entry   exe_entry_inst (.*);
  exe_irq_src exe_irq_src_inst (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic clr();
    {mem_valid, mem_write, tlb_hit, op_valid, in_slot, op_writes_pc} = 6'h00;
    {op_privileged, op_undefined, op_global_base_only} = 3'h0;
    {brk_req, dma_valid, sleep_mode, pin_irq} = 4'h0;
  endtask : clr
  task automatic setsr(input logic [31:0] v);
    sr_load_value = v;
    sr_load = 1;
    step();
    sr_load = 0;
  endtask : setsr
  task automatic wt(input int n, output bit got);
    got = 0;
    for (int i = 0; i < n && !got; i++) begin
      step();
      got = (branch_valid === 1'b1);
    end
  endtask : wt
  task automatic ent(input int n, input logic [31:0] tgt, sr_e, spc_e, ssr_e);
    bit got;
    wt(n, got);
    chk({31'h0, got}, 32'h1);
    chk(branch_target, tgt);
    chk(processor_status_word, sr_e);
    chk(saved_program_counter, spc_e);
    chk(saved_status_copy, ssr_e);
    clr();
    step();
    chk({31'h0, branch_valid}, 32'h0);
  endtask : ent
  task automatic t_prot();
    bit got;
    setsr(32'h00000040);
    {mem_valid, tlb_hit, mem_size} = {2'b11, exe_pkg::SZ_LONG};
    {mem_vaddr, page_access_rights, tlb_way} = {32'h12345678, 2'h2, 2'h3};
    wt(2, got);
    chk({31'h0, got}, 32'h0);
    mem_write = 1;
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40);
    chk(exception_event_code, 12'h0c0);
    chk(fault_virtual_address_reg, 32'h12345678);
    chk(page_entry_high_reg, 22'h048d15);
    chk(mmu_way_counter, 2'h3);
    setsr(32'h00000040);
    {mem_valid, tlb_hit, page_access_rights} = {2'b11, 2'h0};
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40);
    chk(exception_event_code, 12'h0a0);
  endtask : t_prot
  task automatic t_ade();
    setsr(32'h40000040);
    {mem_valid, mem_size, mem_vaddr} = {1'b1, exe_pkg::SZ_LONG, 32'h1002};
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40000040);
    chk(exception_event_code, 12'h0e0);
    chk(fault_virtual_address_reg, 32'h1002);
    setsr(32'h00000040);
    {mem_valid, mem_write, mem_size} = {2'b11, exe_pkg::SZ_BYTE};
    mem_vaddr = 32'h80000000;
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40);
    chk(exception_event_code, 12'h100);
    chk(fault_virtual_address_reg, 32'h80000000);
  endtask : t_ade
  task automatic t_trap();
    setsr(32'h00000040);
    {op_valid, opcode} = {1'b1, 16'hc3ff};
    ent(2, 32'h8c000100, 32'h70000040, next_pc, 32'h40);
    chk(exception_event_code, 12'h160);
    chk(immediate_call_code, 10'h3fc);
  endtask : t_trap
  task automatic t_slot();
    setsr(32'h00000040);
    {op_valid, in_slot, op_writes_pc, opcode} = {3'b111, 16'h402b};
    ent(2, 32'h8c000100, 32'h70000040, branch_pc, 32'h40);
    chk(exception_event_code, 12'h1a0);
  endtask : t_slot
  task automatic t_blk();
    bit got;
    {op_valid, opcode} = {1'b1, 16'hc301};
    wt(2, got);
    chk({31'h0, got}, 32'h1);
    chk(branch_target, 32'ha0000000);
    chk(exception_event_code, 12'h1a0);
    chk(saved_program_counter, branch_pc);
    clr();
  endtask : t_blk
  task automatic t_lvl();
    bit got;
    setsr(32'h00000040);
    {level, raise} = {4'h4, 1'b1};
    step();
    raise = 0;
    wt(8, got);
    chk({31'h0, got}, 32'h0);
    {level, raise} = {4'h5, 1'b1};
    step();
    raise = 0;
    ent(8, 32'h8c000600, 32'h70000040, next_pc, 32'h40);
    chk(interrupt_event_code, 12'h2a0);
    chk(interrupt_event_code_alt, 12'h2a0);
  endtask : t_lvl
  task automatic t_nmi();
    bit got;
    nmi_pin = 1;
    wt(8, got);
    chk({31'h0, got}, 32'h0);
    setsr(32'h000000f0);
    ent(8, 32'h8c000600, 32'h700000f0, next_pc, 32'hf0);
    chk(interrupt_event_code, 12'h1c0);
    chk(interrupt_event_code_alt, 12'h1c0);
    nmi_pin = 0;
  endtask : t_nmi
  task automatic t_pin();
    bit got;
    setsr(32'h70000020);
    {pin_irq, pin_irq_priority} = {1'b1, 4'h5};
    wt(4, got);
    chk({31'h0, got}, 32'h0);
    sleep_mode = 1;
    ent(4, 32'h8c000600, 32'h70000020, next_pc, 32'h70000020);
    chk(interrupt_event_code, 12'h600);
    chk(interrupt_event_code_alt, 12'h600);
    pin_irq_priority = 4'h0;
  endtask : t_pin
  task automatic t_ill();
    bit got;
    setsr(32'h00000040);
    {op_valid, op_privileged, op_global_base_only} = 3'b111;
    opcode = 16'h401e;
    wt(2, got);
    chk({31'h0, got}, 32'h0);
    op_global_base_only = 0;
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40);
    chk(exception_event_code, 12'h180);
    setsr(32'h40000040);
    {op_valid, opcode} = {1'b1, 16'hf000};
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40000040);
    chk(exception_event_code, 12'h180);
  endtask : t_ill
  task automatic t_brk();
    bit got;
    setsr(32'h00000040);
    {brk_req, brk_post} = 2'b11;
    ent(2, 32'h8c000100, 32'h70000040, next_pc, 32'h40);
    chk(exception_event_code, 12'h1e0);
    setsr(32'h00000040);
    {brk_req, brk_post} = 2'b10;
    ent(2, 32'h8c000100, 32'h70000040, cur_pc, 32'h40);
    brk_req = 1;
    wt(2, got);
    chk({31'h0, got}, 32'h0);
    brk_req = 0;
  endtask : t_brk
  task automatic t_dma();
    bit got;
    setsr(32'h00000040);
    {dma_valid, dma_size, dma_addr} = {1'b1, exe_pkg::SZ_LONG, 32'h1004};
    wt(2, got);
    chk({31'h0, got}, 32'h0);
    {dma_size, dma_addr} = {exe_pkg::SZ_WORD, 32'h1001};
    ent(2, 32'h8c000100, 32'h70000040, next_pc, 32'h40);
    chk(exception_event_code, 12'h5c0);
  endtask : t_dma
  task automatic results();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1;
    vbr_load = 1;
    step();
    vbr_load = 0;
    chk(vector_base_reg, 32'h8c000000);
    t_prot();
    t_ade();
    t_trap();
    t_slot();
    t_blk();
    t_lvl();
    t_nmi();
    t_pin();
    t_ill();
    t_brk();
    t_dma();
    results();
  end
endmodule : exe_entry_bench
